// file: verilog/tcs_pkg.sv
/*
 tcs_pkg: shared constants of the channel-select block.
 Assumes word-indexed registers, byte address = 4 * index.
*/
package tcs_pkg;
   // register indices
   localparam logic [7:0] IDX_PEND = 8'h00;
   localparam logic [7:0] IDX_FSTAT = 8'h20;
   localparam logic [7:0] IDX_FTRIG = 8'h29;
   localparam logic [7:0] IDX_CHAN = 8'h30;
   localparam logic [7:0] IDX_RSTEN = 8'h32;
   localparam logic [7:0] IDX_CFG = 8'h33;
   localparam logic [7:0] IDX_GRID = 8'h34;
   localparam logic [7:0] IDX_FCH1 = 8'h35;
   localparam logic [7:0] IDX_FCH2 = 8'h36;
   localparam logic [7:0] IDX_FINE = 8'h62;
   localparam logic [7:0] IDX_RESP = 8'h40;
   localparam logic [7:0] IDX_RDATA = 8'h41;
   localparam logic [7:0] IDX_NVSAVE = 8'h42;
   localparam int unsigned ADDR_LSB = 2;
   // field masks
   localparam logic [15:0] CFG_REQ_ERR = 16'h0001;
   localparam logic [15:0] CFG_FDIS = 16'h0002;
   localparam logic [15:0] RSTEN_SWEN = 16'h0008;
   localparam int unsigned FSTAT_HWEN_BIT = 12;
   localparam int unsigned FLT_W = 4;
   localparam int unsigned PEND_BIT = 8;
   localparam logic [15:0] PEND_ID = 16'h0100;
   // reset values
   localparam logic [15:0] FTRIG_RST = 16'h000f;
   localparam logic [15:0] CFG_RST = 16'h0003;
   localparam logic [15:0] REG_RST = 16'h0000;
   // response status and error codes
   localparam logic [1:0] ST_OK = 2'h0;
   localparam logic [1:0] ST_ERR = 2'h1;
   localparam logic [1:0] ST_PND = 2'h3;
   localparam logic [3:0] ERR_OK = 4'h0;
   localparam logic [3:0] ERR_RO = 4'h1;
   localparam logic [3:0] ERR_RNG = 4'h2;
   localparam logic [3:0] ERR_BUSY = 4'h3;
   localparam logic [3:0] ERR_VND = 4'h4;
   localparam logic [3:0] ERR_FAIL = 4'h8;
   // frequency scaling, result in MHz
   localparam int unsigned FREQ_W = 40;
   localparam logic signed [39:0] MHZ_GRID = 40'sd100;
   localparam logic signed [39:0] MHZ_FCH1 = 40'sd1000000;
   localparam logic signed [39:0] MHZ_FCH2 = 40'sd100;
   // timing
   localparam int unsigned CLK_PERIOD_PS = 4000;
   localparam int unsigned DARK_NS = 1000;
   localparam int unsigned DARK_CYC =
      (DARK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned TUNE_TIMEOUT_US = 10000;
   localparam int unsigned TUNE_TIMEOUT_CYC =
      TUNE_TIMEOUT_US * 1000 / (CLK_PERIOD_PS / 1000);
endpackage : tcs_pkg

// file: verilog/tcs_tune_if.sv
/*
 tcs_tune_if: carries a tuning request from the register bank to the
 tuning sequencer and its outcome back. Single clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
interface tcs_tune_if;
   logic start;
   logic [15:0] chan;
   logic [15:0] grid;
   logic [15:0] fch1;
   logic [15:0] fch2;
   logic [15:0] fine;
   logic busy;
   logic done;
   logic fail;
   logic go;
   logic [tcs_pkg::FREQ_W-1:0] freq;
   modport bank (output start, chan, grid, fch1, fch2, fine,
                 input busy, done, fail, go, freq);
   modport seq (input start, chan, grid, fch1, fch2, fine,
                output busy, done, fail, go, freq);
endinterface : tcs_tune_if
`default_nettype wire

// file: verilog/tcs_tuner.sv
/*
 tcs_tuner: tuning sequencer. Holds the laser dark, then asks the
 laser to tune and waits for lock, failure or timeout.
 Assumes lock and fail come from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module tcs_tuner #(
   parameter int unsigned TIMEOUT_CYC = tcs_pkg::TUNE_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // request and outcome
   tcs_tune_if.seq tn,
   // laser tuning feedback pins
   input wire logic lock_pin,
   input wire logic fail_pin
);
   typedef enum logic [1:0] {T_IDLE, T_DARK, T_WAIT} tcs_tstate_t;
   typedef struct packed {
      tcs_tstate_t st;
      logic [31:0] cnt;
      logic lk1, lk2, fl1, fl2;
      logic busy, done, fail, go;
      logic [tcs_pkg::FREQ_W-1:0] freq;
   } tcs_tun_t;
   tcs_tun_t s, n;

   function automatic logic [39:0] f_freq(input logic [15:0] ch,
      input logic [15:0] g, input logic [15:0] f1,
      input logic [15:0] f2, input logic [15:0] ft);
      logic signed [39:0] d;
      d = $signed({24'h0, ch}) - 40'sd1;
      f_freq = 40'(d * $signed({{24{g[15]}}, g}) * tcs_pkg::MHZ_GRID
         + $signed({24'h0, f1}) * tcs_pkg::MHZ_FCH1
         + $signed({24'h0, f2}) * tcs_pkg::MHZ_FCH2
         + $signed({{24{ft[15]}}, ft}));
   endfunction : f_freq

   // sequencer next state
   always_comb begin
      n = s;
      n.lk1 = lock_pin;
      n.lk2 = s.lk1;
      n.fl1 = fail_pin;
      n.fl2 = s.fl1;
      n.done = 1'b0;
      case (s.st)
         T_IDLE: begin
            if (tn.start) begin
               n.freq = f_freq(tn.chan, tn.grid, tn.fch1, tn.fch2, tn.fine);
               n.cnt = 32'h0;
               n.busy = 1'b1;
               n.fail = 1'b0;
               n.st = T_DARK;
            end
         end
         T_DARK: begin
            n.cnt = s.cnt + 32'h1;
            if (s.cnt >= 32'(tcs_pkg::DARK_CYC - 1)) begin
               n.cnt = 32'h0;
               n.go = 1'b1;
               n.st = T_WAIT;
            end
         end
         T_WAIT: begin
            n.cnt = s.cnt + 32'h1;
            // timeout counts as a tuning failure
            if (s.lk2 | s.fl2 | (s.cnt >= 32'(TIMEOUT_CYC - 1))) begin
               n.fail = ~s.lk2;
               n.done = 1'b1;
               n.busy = 1'b0;
               n.go = 1'b0;
               n.st = T_IDLE;
            end
         end
         default: n.st = T_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign tn.busy = s.busy;
   assign tn.done = s.done;
   assign tn.fail = s.fail;
   assign tn.go = s.go;
   assign tn.freq = s.freq;
endmodule : tcs_tuner
`default_nettype wire

// file: verilog/tcs_chan_sel.sv
/*
 tcs_chan_sel: channel-select register bank and output gating of a
 tunable transmitter, reached as an AHB-Lite slave.
 Assumes one clock, one master, word accesses only.
*/
// What this block does
// - channel held as 16-bit unsigned; read answers OK, no side effect
// - good channel write starts tuning, answers pending status with pending id
// - channel write is pending, response flagged command-pending
// - failed access answers execution error, data 0, error code set
// - channel zero is undefined and refused
// - invalid channel write keeps old value, signals execution error
// - channel outside configured range signals execution error
// - errors other than tuning failure leave channel unchanged
// - frequency = (ch-1)*grid + first channel freq + fine tune
// - grid spacing sign sets frequency direction
// - enabled output goes dark, then returns on new channel
// - write accepted when disabled; output stays off till enabled
// - pin rising alone never re-enables; software must set enable
// - output off on triggered fatal with fatal-disable, or enables low
// - fatal-disable enable is config register bit 0x0002
// - software enable is reset/enable register bit 0x0008
// - hardware enable pin shows at fatal status bit 0x1000
// - tuning failure leaves the output off
// - channel default loads from storage; saved on request
// - pending bit clears when tuning ends; host polls it
// - failed pending tuning reports error code 0x8
// - service request goes low when pending op fails
// - set trigger bits let matching status bits raise fatal
`timescale 1ns/10ps
`default_nettype none
module tcs_chan_sel #(
   parameter logic [15:0] CHAN_MIN = 16'h0001,
   parameter logic [15:0] CHAN_MAX = 16'hffff,
   parameter int unsigned TIMEOUT_CYC = tcs_pkg::TUNE_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   // pins
   input wire logic hw_output_enable_pin,
   input wire logic [tcs_pkg::FLT_W-1:0] fault_pin,
   input wire logic tune_lock_pin,
   input wire logic tune_fail_pin,
   output logic service_request_line_n,
   // laser control
   output logic laser_enable,
   output logic tune_go,
   output logic [tcs_pkg::FREQ_W-1:0] target_freq,
   // non-volatile storage
   input wire logic [15:0] nv_chan_default,
   output logic nv_save,
   output logic [15:0] nv_chan
);
   typedef struct packed {
      logic rdy;
      logic [31:0] rdata;
      logic wr_pend;
      logic [7:0] wr_idx;
      logic loaded;
      logic [15:0] chan;
      logic [15:0] grid;
      logic [15:0] fch1;
      logic [15:0] fch2;
      logic [15:0] fine;
      logic [15:0] rsten;
      logic [15:0] cfg;
      logic [15:0] ftrig;
      logic [tcs_pkg::FLT_W-1:0] flt_lat;
      logic [tcs_pkg::FLT_W-1:0] flt1, flt2;
      logic en1, en2, en_prev;
      logic pend;
      logic [3:0] err;
      logic sreq_n;
      logic tuned;
      logic laser;
      logic start;
      logic [1:0] resp_st;
      logic [3:0] resp_err;
      logic [15:0] resp_data;
      logic nv_save;
      logic [15:0] nv_chan;
   } tcs_st_t;

   tcs_st_t s, n;
   tcs_tune_if tn ();

   // fatal status with the pin at its bit
   function automatic logic [15:0] f_fstat(input tcs_st_t st);
      f_fstat = 16'h0000;
      f_fstat[tcs_pkg::FLT_W-1:0] = st.flt_lat;
      f_fstat[tcs_pkg::FSTAT_HWEN_BIT] = st.en2;
   endfunction : f_fstat

   // register read view
   function automatic logic [15:0] f_rd(input logic [7:0] idx,
      input tcs_st_t st);
      case (idx)
         tcs_pkg::IDX_PEND: f_rd = ({15'h0, st.pend} << tcs_pkg::PEND_BIT)
            | {12'h0, st.err};
         tcs_pkg::IDX_FSTAT: f_rd = f_fstat(st);
         tcs_pkg::IDX_FTRIG: f_rd = st.ftrig;
         tcs_pkg::IDX_CHAN: f_rd = st.chan;
         tcs_pkg::IDX_RSTEN: f_rd = st.rsten;
         tcs_pkg::IDX_CFG: f_rd = st.cfg;
         tcs_pkg::IDX_GRID: f_rd = st.grid;
         tcs_pkg::IDX_FCH1: f_rd = st.fch1;
         tcs_pkg::IDX_FCH2: f_rd = st.fch2;
         tcs_pkg::IDX_FINE: f_rd = st.fine;
         tcs_pkg::IDX_RESP: f_rd = {10'h0, st.resp_err, st.resp_st};
         tcs_pkg::IDX_RDATA: f_rd = st.resp_data;
         default: f_rd = 16'h0000;
      endcase
   endfunction : f_rd

   // register map membership
   function automatic logic f_mapped(input logic [7:0] idx);
      case (idx)
         tcs_pkg::IDX_PEND, tcs_pkg::IDX_FSTAT, tcs_pkg::IDX_FTRIG,
         tcs_pkg::IDX_CHAN, tcs_pkg::IDX_RSTEN, tcs_pkg::IDX_CFG,
         tcs_pkg::IDX_GRID, tcs_pkg::IDX_FCH1, tcs_pkg::IDX_FCH2,
         tcs_pkg::IDX_FINE, tcs_pkg::IDX_RESP, tcs_pkg::IDX_RDATA,
         tcs_pkg::IDX_NVSAVE: f_mapped = 1'b1;
         default: f_mapped = 1'b0;
      endcase
   endfunction : f_mapped

   // tuning sequencer
   tcs_tuner #(
      .TIMEOUT_CYC(TIMEOUT_CYC)
   ) u_tuner (
      .hclk(hclk),
      .hresetn(hresetn),
      .tn(tn.seq),
      .lock_pin(tune_lock_pin),
      .fail_pin(tune_fail_pin)
   );

   assign tn.start = s.start;
   assign tn.chan = s.chan;
   assign tn.grid = s.grid;
   assign tn.fch1 = s.fch1;
   assign tn.fch2 = s.fch2;
   assign tn.fine = s.fine;

   // next state of the whole bank
   always_comb begin
      logic acc;
      logic [7:0] idx;
      logic [15:0] w;
      logic [15:0] rv;
      logic upd;
      logic [1:0] rst;
      logic [3:0] rerr;
      logic [15:0] rdat;
      logic fatal;
      logic off;
      acc = 1'b0;
      idx = 8'h00;
      w = 16'h0000;
      rv = 16'h0000;
      upd = 1'b0;
      rst = tcs_pkg::ST_OK;
      rerr = tcs_pkg::ERR_OK;
      rdat = 16'h0000;
      fatal = 1'b0;
      off = 1'b0;
      n = s;
      n.start = 1'b0;
      n.nv_save = 1'b0;
      // pins pass two flops before use
      n.en1 = hw_output_enable_pin;
      n.en2 = s.en1;
      n.en_prev = s.en2;
      n.flt1 = fault_pin;
      n.flt2 = s.flt1;
      // channel default taken once after reset release
      if (!s.loaded) begin
         n.chan = nv_chan_default;
         n.loaded = 1'b1;
      end
      // pin falling drops the software enable
      if (s.en_prev & ~s.en2) begin
         n.rsten = s.rsten & ~tcs_pkg::RSTEN_SWEN;
      end
      // write data phase: one wait state so a read sees the update
      if (s.wr_pend) begin
         n.rdy = 1'b1;
         n.wr_pend = 1'b0;
         w = hwdata[15:0];
         upd = 1'b1;
         rdat = w;
         case (s.wr_idx)
            tcs_pkg::IDX_CHAN: begin
               // refused writes leave channel as it is
               if (s.pend | tn.busy) begin
                  rst = tcs_pkg::ST_ERR;
                  rerr = tcs_pkg::ERR_BUSY;
                  rdat = 16'h0000;
               // zero or out of range refused
               end else if ((w == 16'h0000) | (w < CHAN_MIN)
                            | (w > CHAN_MAX)) begin
                  rst = tcs_pkg::ST_ERR;
                  rerr = tcs_pkg::ERR_RNG;
                  rdat = 16'h0000;
               end else begin
                  n.chan = w;
                  n.start = 1'b1;
                  n.pend = 1'b1;
                  n.err = tcs_pkg::ERR_OK;
                  n.sreq_n = 1'b1;
                  n.tuned = 1'b0;
                  rst = tcs_pkg::ST_PND;
                  rdat = tcs_pkg::PEND_ID;
               end
            end
            // latched faults clear by writing ones
            tcs_pkg::IDX_FSTAT:
               n.flt_lat = s.flt_lat & ~w[tcs_pkg::FLT_W-1:0];
            tcs_pkg::IDX_FTRIG: n.ftrig = w;
            tcs_pkg::IDX_RSTEN: n.rsten = w;
            tcs_pkg::IDX_CFG: n.cfg = w;
            tcs_pkg::IDX_GRID: n.grid = w;
            tcs_pkg::IDX_FCH1: n.fch1 = w;
            tcs_pkg::IDX_FCH2: n.fch2 = w;
            tcs_pkg::IDX_FINE: n.fine = w;
            // save current channel as the stored default
            tcs_pkg::IDX_NVSAVE: begin
               n.nv_save = 1'b1;
               n.nv_chan = s.chan;
            end
            tcs_pkg::IDX_PEND, tcs_pkg::IDX_RESP, tcs_pkg::IDX_RDATA: begin
               rst = tcs_pkg::ST_ERR;
               rerr = tcs_pkg::ERR_RO;
               rdat = 16'h0000;
            end
            default: begin
               rst = tcs_pkg::ST_ERR;
               rerr = tcs_pkg::ERR_VND;
               rdat = 16'h0000;
            end
         endcase
      end else begin
         acc = hsel & htrans[1] & hready & s.rdy;
         idx = haddr[tcs_pkg::ADDR_LSB+7:tcs_pkg::ADDR_LSB];
         if (acc & hwrite) begin
            n.rdy = 1'b0;
            n.wr_pend = 1'b1;
            n.wr_idx = idx;
         end else if (acc) begin
            // mapped reads answer OK, unmapped ones a vendor error; only a pending read changes more
            rv = f_rd(idx, s);
            n.rdata = {16'h0000, rv};
            upd = (idx != tcs_pkg::IDX_RESP) & (idx != tcs_pkg::IDX_RDATA);
            rdat = rv;
            if (!f_mapped(idx)) begin
               rst = tcs_pkg::ST_ERR;
               rerr = tcs_pkg::ERR_VND;
               rdat = 16'h0000;
            end
            // polling the pending register acknowledges the request
            if (idx == tcs_pkg::IDX_PEND) begin
               n.sreq_n = 1'b1;
            end
         end
      end
      if (upd) begin
         n.resp_st = rst;
         n.resp_err = rerr;
         n.resp_data = rdat;
      end
      // pending ends with the recorded outcome
      if (tn.done) begin
         n.pend = 1'b0;
         if (tn.fail) begin
            // failure code kept for later polls
            n.err = tcs_pkg::ERR_FAIL;
            // output stays dark after a failure
            n.tuned = 1'b0;
            // service request on failed pending op
            if ((s.cfg & tcs_pkg::CFG_REQ_ERR) != 16'h0000) begin
               n.sreq_n = 1'b0;
            end
         end else begin
            n.tuned = 1'b1;
         end
      end
      // fault set wins over a clear in the same cycle
      n.flt_lat = n.flt_lat | s.flt2;
      // only triggered status bits raise fatal
      fatal = (f_fstat(s) & s.ftrig) != 16'h0000;
      off = (fatal & ((s.cfg & tcs_pkg::CFG_FDIS) != 16'h0000))
         | ((s.rsten & tcs_pkg::RSTEN_SWEN) == 16'h0000)
         | ~s.en2;
      // dark while tuning, lit once locked
      n.laser = ~off & s.tuned & ~tn.busy & ~s.pend;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s <= '0;
         s.rdy <= 1'b1;
         s.sreq_n <= 1'b1;
         s.ftrig <= tcs_pkg::FTRIG_RST;
         s.cfg <= tcs_pkg::CFG_RST;
         s.rsten <= tcs_pkg::REG_RST;
      end else begin
         s <= n;
      end
   end

   // outputs straight from flops; hresp tied low
   assign hreadyout = s.rdy;
   assign hrdata = s.rdata;
   assign hresp = 1'b0;
   assign service_request_line_n = s.sreq_n;
   assign laser_enable = s.laser;
   assign tune_go = tn.go;
   assign target_freq = tn.freq;
   assign nv_save = s.nv_save;
   assign nv_chan = s.nv_chan;
endmodule : tcs_chan_sel
`default_nettype wire

// file: bench/tcs_chan_sel_sva.sv
/*
 tcs_chan_sel_sva: port checker of the channel-select block.
 Assumes it is bound onto tcs_chan_sel; one clock, reset low.
*/
`timescale 1ns/10ps
`default_nettype none
module tcs_chan_sel_sva (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // bus
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   input wire logic hresp,
   // pins
   input wire logic hw_output_enable_pin,
   input wire logic service_request_line_n,
   input wire logic laser_enable,
   input wire logic tune_go,
   input wire logic nv_save
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // transfer taken in its address phase
   sequence s_take;
      hsel && htrans[1] && hready && hreadyout;
   endsequence
   sequence s_wr;
      s_take ##0 hwrite;
   endsequence
   sequence s_rd;
      s_take ##0 !hwrite;
   endsequence
   AST_RD_NOWAIT: assert property (
      s_rd |=> hreadyout && hrdata[31:16] == 16'h0000)
      else $error("read answer late or too wide");
   AST_WR_WAIT: assert property (
      s_wr |=> !hreadyout ##1 hreadyout)
      else $error("write wait state wrong");
   AST_RESP_OKAY: assert property (
      hresp == 1'b0)
      else $error("bus response not okay");
   // pin low darkens (sync stages allowed for)
   AST_PIN_OFF: assert property (
      (!hw_output_enable_pin) [*5] |-> !laser_enable)
      else $error("output on with pin low");
   AST_DARK_TUNE: assert property (
      tune_go |-> !laser_enable)
      else $error("output on while tuning");
   AST_PIN_RISE: assert property (
      $rose(hw_output_enable_pin) && !laser_enable |=> !laser_enable [*2])
      else $error("pin rise turned output on");
   AST_SRQ_FAIL: assert property (
      $fell(service_request_line_n) |-> $past(tune_go) || $past(tune_go, 2))
      else $error("service request without tuning");
   AST_SAVE_PULSE: assert property (
      nv_save |=> !nv_save)
      else $error("save request too long");
endmodule : tcs_chan_sel_sva
bind tcs_chan_sel tcs_chan_sel_sva u_sva (
   .hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hreadyout,
   .hrdata, .hresp, .hw_output_enable_pin, .service_request_line_n,
   .laser_enable, .tune_go, .nv_save);
`default_nettype wire

// file: bench/tcs_laser_model.sv
/*
 tcs_laser_model: laser tuning section behind the block's pins.
 Assumes the request comes from the block; delay set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module tcs_laser_model (
   // clock
   input wire logic hclk,
   // request and scenario controls
   input wire logic tune_go,
   input wire logic fail_mode,
   input wire logic [7:0] delay,
   // tuning feedback
   output logic lock,
   output logic fail
);
   logic [7:0] cnt_q;
   // settle count restarts with every request
   always_ff @(posedge hclk) begin
      if (!tune_go) begin
         cnt_q <= 8'h00;
      end else if (cnt_q != 8'hff) begin
         cnt_q <= cnt_q + 8'h01;
      end
   end
   // no outcome outside a request, so stale lock cannot end a tune
   assign lock = tune_go && !fail_mode && cnt_q >= delay;
   assign fail = tune_go && fail_mode && cnt_q >= delay;
endmodule : tcs_laser_model
`default_nettype wire

// file: bench/tcs_chan_sel_tb_top.sv
/*
 tcs_chan_sel_tb_top: self-checking bench of the channel-select block.
 Assumes the laser model and the bound checker beside it.
*/
`timescale 1ns/10ps
`default_nettype none
module tcs_chan_sel_tb_top;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, pin, fm, lock;
   logic fail, service_request_line_n, laser_enable, tune_go, nv_save;
   logic [1:0] htrans;
   logic [3:0] fault;
   logic [7:0] dly;
   logic [15:0] nv_chan, nv_def, nv_seen, ch, grid;
   logic [31:0] haddr, hwdata, hrdata, seed, q;
   logic [39:0] target_freq;
   logic [39:0] exp_q[$];
   string nm_q[$];
   int fails, checks;
   bit rd_pend;
   // 250 MHz clock
   initial begin
      hclk = 1'b0;
      forever #2 hclk = ~hclk;
   end
   tcs_chan_sel #(.CHAN_MAX(16'h0100), .TIMEOUT_CYC(50)) u_dut (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp,
      .hw_output_enable_pin(pin), .fault_pin(fault), .tune_lock_pin(lock),
      .tune_fail_pin(fail), .service_request_line_n, .laser_enable,
      .tune_go, .target_freq, .nv_chan_default(nv_def), .nv_save, .nv_chan);
   tcs_laser_model u_laser (
      .hclk, .tune_go, .fail_mode(fm), .delay(dly), .lock, .fail);
   function automatic logic [31:0] rnd_next(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : rnd_next
   // expected target in MHz; fine tune stays at zero
   function automatic logic [39:0] f_exp(input logic [15:0] c, g);
      return ($signed({24'h0, c}) - 40'sd1) * $signed({{24{g[15]}}, g})
         * tcs_pkg::MHZ_GRID + 40'sd196 * tcs_pkg::MHZ_FCH1
         + 40'sd300 * tcs_pkg::MHZ_FCH2;
   endfunction : f_exp
   task automatic check(input string nm, input logic [39:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic print_verdict();
      if (fails == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict
   // one transfer; the note goes in only once the address is taken
   task automatic bus(input logic w, input logic [31:0] a, d, e,
      input string nm, output logic [31:0] r);
      int n;
      n = 0;
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (nm != "") begin
         exp_q.push_back({8'h0, e});
         nm_q.push_back(nm);
      end
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      r = hrdata;
      if (n >= 50) begin
         fails++;
         print_verdict();
      end
   endtask : bus
   task automatic rd(input logic [31:0] a, e, input string nm);
      bus(1'b0, a, 32'h0, e, nm, q);
   endtask : rd
   task automatic wr(input logic [31:0] a, d);
      bus(1'b1, a, d, 32'h0, "", q);
   endtask : wr
   // response code {error, status} and its data word
   task automatic rsp(input logic [5:0] c, input logic [15:0] d);
      rd(32'h100, {26'h0, c}, "response");
      rd(32'h104, {16'h0, d}, "response data");
   endtask : rsp
   // host polls the pending bit; q keeps the last answer
   task automatic poll();
      q = 32'h100;
      for (int n = 0; q[8] === 1'b1 && n < 400; n++) begin
         bus(1'b0, 32'h0, 32'h0, 32'h0, "", q);
      end
      check("pending", {8'h0, q}, 40'h0);
   endtask : poll
   // bounded wait on the output or the tuning request
   task automatic wait_on(input logic go, input logic v);
      int n;
      for (n = 0; (go ? tune_go : laser_enable) !== v && n < 600; n++) begin
         @(posedge hclk);
      end
      check(go ? "tune" : "laser", {39'h0, v}, {39'h0, v ^ (n >= 600)});
      if (n >= 600) print_verdict();
   endtask : wait_on
   // compares noted reads as they complete; catches save requests
   always @(posedge hclk) begin
      if (rd_pend && hreadyout && exp_q.size() > 0) begin
         check(nm_q.pop_front(), {8'h0, hrdata}, exp_q.pop_front());
      end
      if (hreadyout) rd_pend = hresetn && hsel && htrans[1] && !hwrite;
      if (nv_save) nv_seen = nv_chan;
   end
   initial begin
      seed = rnd_next(32'h8512b47e);
      nv_def <= {8'h0, seed[7:0]} | 16'h0001;
      hresetn <= 1'b0;
      hsel <= 1'b0;
      htrans <= 2'h0;
      haddr <= 32'h0;
      hwrite <= 1'b0;
      hwdata <= 32'h0;
      pin <= 1'b1;
      fault <= 4'h0;
      fm <= 1'b0;
      dly <= 8'h3;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      repeat (2) @(posedge hclk);
      rd(32'hcc, 32'h3, "config");
      rd(32'h80, 32'h1000, "fatal status");
      rd(32'hc0, {16'h0, nv_def}, "channel");
      rsp(6'h00, nv_def);
      rd(32'h3fc, 32'h0, "unmapped");
      rsp(6'h11, 16'h0);
      wr(32'h0, 32'h5);
      rsp(6'h05, 16'h0);
      wr(32'hd4, 32'hc4);
      wr(32'hd8, 32'h12c);
      wr(32'hc8, 32'h8);
      // retune to random channels with both grid signs
      for (int i = 0; i < 3; i++) begin
         seed = rnd_next(seed);
         grid = i[0] ? 16'hffce : {8'h0, seed[15:8]};
         ch = {8'h0, seed[7:0]} | 16'h0001;
         dly <= {4'h0, seed[19:16]} + 8'h1;
         wr(32'hd0, {16'h0, grid});
         wr(32'hc0, {16'h0, ch});
         rsp(6'h03, 16'h0100);
         check("laser", {39'h0, laser_enable}, 40'h0);
         rd(32'h0, 32'h100, "pending");
         poll();
         wait_on(1'b0, 1'b1);
         check("freq", target_freq, f_exp(ch, grid));
         rd(32'hc0, {16'h0, ch}, "channel");
      end
      // refused channels leave the stored one
      wr(32'hc0, 32'h0);
      rsp(6'h09, 16'h0);
      wr(32'hc0, 32'h200);
      rsp(6'h09, 16'h0);
      rd(32'hc0, {16'h0, ch}, "channel");
      // failing tune, second write refused meanwhile
      fm <= 1'b1;
      wr(32'hc0, 32'h2);
      wr(32'hc0, 32'h3);
      rsp(6'h0d, 16'h0);
      wait_on(1'b1, 1'b1);
      wait_on(1'b1, 1'b0);
      repeat (4) @(posedge hclk);
      check("service", {39'h0, service_request_line_n}, 40'h0);
      rd(32'h0, 32'h8, "pending");
      repeat (2) @(posedge hclk);
      check("laser", {39'h0, laser_enable}, 40'h0);
      check("service", {39'h0, service_request_line_n}, 40'h1);
      fm <= 1'b0;
      // pin low: channel still taken, output waits for software
      pin <= 1'b0;
      wr(32'hc0, 32'h4);
      rsp(6'h03, 16'h0100);
      poll();
      pin <= 1'b1;
      repeat (20) @(posedge hclk);
      check("laser", {39'h0, laser_enable}, 40'h0);
      wr(32'hc8, 32'h8);
      wait_on(1'b0, 1'b1);
      // latched fault under fatal disable, config and trigger
      fault <= 4'h1;
      wait_on(1'b0, 1'b0);
      rd(32'h80, 32'h1001, "fatal status");
      wr(32'hcc, 32'h1);
      wait_on(1'b0, 1'b1);
      wr(32'hcc, 32'h3);
      wait_on(1'b0, 1'b0);
      wr(32'ha4, 32'he);
      wait_on(1'b0, 1'b1);
      wr(32'h108, 32'h0);
      repeat (4) @(posedge hclk);
      check("saved", {24'h0, nv_seen}, 40'h4);
      print_verdict();
   end
endmodule : tcs_chan_sel_tb_top
`default_nettype wire
